// file: src/mbac_pkg.sv
// mode based access control: shared constants, register map and carrier types
// assumes a single 200 MHz clock domain and an APB register port
`default_nettype none

package mbac_pkg;

	// ==========================================================
	// sizes
	localparam int ADDR_W = 8;
	localparam int NSEG = 4;
	localparam int NPER = 8;
	localparam int SEG_IDX_W = 2;
	localparam int PER_IDX_W = 3;
	localparam int IRQ_W = 2;

	// ==========================================================
	// register map, byte addresses
	localparam logic [ADDR_W-1:0] OFF_PART = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_PTR = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_SEG_ATTR = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_BOOT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_USR_GRANT = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_CLS_GRANT = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h1C;

	// address regions: control 0x00-0x1F, segments 0x20-0x3F, peripherals 0x40-0x5F
	localparam int REGION_LSB = 5;
	localparam int REGION_W = 3;
	localparam logic [REGION_W-1:0] REGION_CTRL = 3'h0;
	localparam logic [REGION_W-1:0] REGION_SEG = 3'h1;
	localparam logic [REGION_W-1:0] REGION_PER = 3'h2;
	localparam int SEG_IDX_LSB = 3;
	localparam int SEG_LIM_BIT = 2;
	localparam int PER_IDX_LSB = 2;
	localparam logic [1:0] WORD_ALIGN = 2'h0;

	// ==========================================================
	// fields and reset values
	localparam int SEG_EN_LSB = 0;
	localparam int SEG_RD_LSB = 4;
	localparam int SEG_WR_LSB = 8;
	localparam int SEG_ATTR_W = 12;
	localparam logic [SEG_ATTR_W-1:0] SEG_ATTR_RST = 12'h000;
	localparam int BOOT_DONE_BIT = 0;
	localparam int IRQ_MEM_BIT = 0;
	localparam int IRQ_REG_BIT = 1;
	localparam logic [31:0] PTR_RST = 32'h0000_0000;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [NPER-1:0] GRANT_RST = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

	// fixed partition, hard-wired; no write path exists
	localparam logic [31:0] PART_BASE = 32'h0000_8000;
	localparam logic [31:0] PART_LIMIT = 32'h0000_8FFF;
	localparam logic [31:0] PART_CFG_VAL = {PART_LIMIT[31:16], PART_BASE[31:16]};

	// peripheral registers every mode may reach (basic cpu operation)
	localparam logic [NPER-1:0] BASIC_MASK = 8'h03;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		MODE_SYS = 3'h1,
		MODE_USR = 3'h2,
		MODE_CLS = 3'h4
	} mbac_mode_t;

	typedef enum logic [1:0] {
		BOOT_INIT = 2'h1,
		BOOT_RUN = 2'h2
	} mbac_boot_t;

	typedef struct packed {
		logic [31:0] limit;
		logic [31:0] base;
	} mbac_seg_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
	} mbac_mem_req_t;

	typedef struct packed {
		logic done;
		logic grant;
		logic fault;
	} mbac_mem_resp_t;

endpackage

`default_nettype wire

// file: src/mbac_seg_match.sv
// mode based access control: segment window match for one memory request
// purely combinational; the caller registers the verdict
`timescale 1ns/1ps
`default_nettype none

module mbac_seg_match (
	input wire logic [31:0] addr,
	input wire logic write,
	input wire mbac_pkg::mbac_seg_t [mbac_pkg::NSEG-1:0] seg,
	input wire logic [mbac_pkg::SEG_ATTR_W-1:0] attr,
	output logic hit_ok
);
	import mbac_pkg::*;

	logic [NSEG-1:0] ok;

	// ==========================================================
	// per segment window and permission
	genvar g;
	generate
		for (g = 0; g < NSEG; g++) begin : g_seg
			logic perm;
			assign perm = write ? attr[SEG_WR_LSB + g] : attr[SEG_RD_LSB + g];
			// a disabled segment never matches, so reset leaves every segment window closed
			assign ok[g] = attr[SEG_EN_LSB + g] && perm &&
				(addr >= seg[g].base) && (addr <= seg[g].limit);
		end
	endgenerate

	assign hit_ok = |ok;

endmodule // mbac_seg_match

`default_nettype wire

// file: src/mbac_top.sv
// mode based access control: apb register file, peripheral register guard,
// memory partition and segment check, violation exception and interrupt
// assumes cpu_mode and mem_req come from logic on clk; the apb master is the cpu
`timescale 1ns/1ps
`default_nettype none

// Operation
// - partition boundaries hard-wired, never writable
// - segments all disabled after reset
// - firmware boot write completes default setup
// - segment table pointer writable only privileged
// - segment attributes software changeable when privileged
// - mmu control registers privileged mode only
// - privileged mode reaches all peripheral registers
// - unprivileged mode gets only basic registers
// - mmu grant opens single peripheral register
// - grants exist only for user, contactless
// - all other access attributes hard-wired
// - reset restores peripheral values and permissions
module mbac_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mbac_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire mbac_pkg::mbac_mode_t cpu_mode,
	input wire mbac_pkg::mbac_mem_req_t mem_req,
	output var mbac_pkg::mbac_mem_resp_t mem_resp,
	output logic [mbac_pkg::NPER-1:0][31:0] periph_ctrl,
	output logic [31:0] seg_table_ptr,
	output logic violation_exc,
	output logic irq
);
	import mbac_pkg::*;

	// ==========================================================
	// state
	logic [31:0] seg_ptr_q;
	logic [SEG_ATTR_W-1:0] seg_attr_q;
	mbac_seg_t [NSEG-1:0] seg_q;
	logic [NPER-1:0] usr_grant_q;
	logic [NPER-1:0] cls_grant_q;
	logic [NPER-1:0][31:0] per_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	mbac_boot_t boot_q;
	logic [31:0] rdata_q;
	logic err_q;
	logic den_q;
	logic exc_q;
	mbac_mem_resp_t resp_q;

	// ==========================================================
	// apb decode
	logic setup;
	logic access;
	logic wr_ok;
	logic sys;
	logic [REGION_W-1:0] region;
	logic [SEG_IDX_W-1:0] seg_idx;
	logic [PER_IDX_W-1:0] per_idx;
	logic mapped;
	logic allow;
	logic ro_viol;
	logic [31:0] rd_val;

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign region = paddr[REGION_LSB +: REGION_W];
	assign seg_idx = paddr[SEG_IDX_LSB +: SEG_IDX_W];
	assign per_idx = paddr[PER_IDX_LSB +: PER_IDX_W];
	assign sys = (cpu_mode == MODE_SYS);

	always_comb begin
		rd_val = WORD_RST;
		mapped = (paddr[1:0] == WORD_ALIGN);
		allow = sys;
		ro_viol = 1'b0;
		case (region)
			REGION_CTRL: begin
				case (paddr)
					OFF_PART: begin
						rd_val = PART_CFG_VAL;
						ro_viol = 1'b1;
					end
					OFF_PTR: rd_val = seg_ptr_q;
					OFF_SEG_ATTR: rd_val = {{(32-SEG_ATTR_W){1'b0}}, seg_attr_q};
					OFF_BOOT: begin
						rd_val = {31'h0, boot_q == BOOT_RUN};
						ro_viol = (boot_q == BOOT_RUN);
					end
					OFF_USR_GRANT: rd_val = {{(32-NPER){1'b0}}, usr_grant_q};
					OFF_CLS_GRANT: rd_val = {{(32-NPER){1'b0}}, cls_grant_q};
					OFF_IRQ_STAT: rd_val = {{(32-IRQ_W){1'b0}}, irq_stat_q};
					OFF_IRQ_MASK: rd_val = {{(32-IRQ_W){1'b0}}, irq_mask_q};
					default: mapped = 1'b0;
				endcase
			end
			REGION_SEG: begin
				rd_val = paddr[SEG_LIM_BIT] ? seg_q[seg_idx].limit : seg_q[seg_idx].base;
			end
			REGION_PER: begin
				rd_val = per_q[per_idx];
				// only user and contactless carry configurable grants
				allow = sys || BASIC_MASK[per_idx] ||
					((cpu_mode == MODE_USR) && usr_grant_q[per_idx]) ||
					((cpu_mode == MODE_CLS) && cls_grant_q[per_idx]);
			end
			default: mapped = 1'b0;
		endcase
	end

	// ==========================================================
	// apb answer: verdict taken in setup, held through the access cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= WORD_RST;
			err_q <= 1'b0;
			den_q <= 1'b0;
		end else if (ce && setup) begin
			den_q <= mapped && !allow;
			err_q <= !mapped || !allow || (pwrite && ro_viol);
			rdata_q <= (mapped && allow && !pwrite) ? rd_val : WORD_RST;
		end
	end

	// a frozen block must stall the bus rather than drop the access
	assign pready = ce;
	assign pslverr = access && err_q;
	assign prdata = rdata_q;
	assign wr_ok = ce && access && pwrite && !err_q;

	// ==========================================================
	// mmu configuration
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			seg_ptr_q <= PTR_RST;
		end else if (wr_ok && paddr == OFF_PTR) begin
			seg_ptr_q <= pwdata;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			seg_attr_q <= SEG_ATTR_RST;
		end else if (wr_ok && paddr == OFF_SEG_ATTR) begin
			seg_attr_q <= pwdata[SEG_ATTR_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NSEG; i++) begin
				seg_q[i] <= {WORD_RST, WORD_RST};
			end
		end else if (wr_ok && region == REGION_SEG) begin
			if (paddr[SEG_LIM_BIT]) begin
				seg_q[seg_idx].limit <= pwdata;
			end else begin
				seg_q[seg_idx].base <= pwdata;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			usr_grant_q <= GRANT_RST;
			cls_grant_q <= GRANT_RST;
		end else if (wr_ok) begin
			if (paddr == OFF_USR_GRANT) begin
				usr_grant_q <= pwdata[NPER-1:0];
			end
			if (paddr == OFF_CLS_GRANT) begin
				cls_grant_q <= pwdata[NPER-1:0];
			end
		end
	end

	// boot stage: firmware closes it once; later writes are refused
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			boot_q <= BOOT_INIT;
		end else if (ce) begin
			case (boot_q)
				BOOT_INIT: begin
					if (wr_ok && paddr == OFF_BOOT && pwdata[BOOT_DONE_BIT]) begin
						boot_q <= BOOT_RUN;
					end
				end
				BOOT_RUN: boot_q <= BOOT_RUN;
				default: boot_q <= BOOT_INIT;
			endcase
		end
	end

	// ==========================================================
	// peripheral control registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NPER; i++) begin
				per_q[i] <= WORD_RST;
			end
		end else if (wr_ok && region == REGION_PER) begin
			per_q[per_idx] <= pwdata;
		end
	end

	assign periph_ctrl = per_q;
	assign seg_table_ptr = seg_ptr_q;

	// ==========================================================
	// memory check: partition is for contactless only, segments gate user
	logic in_part;
	logic seg_ok;
	logic mem_ok;

	mbac_seg_match u_seg (
		.addr(mem_req.addr),
		.write(mem_req.write),
		.seg(seg_q),
		.attr(seg_attr_q),
		.hit_ok(seg_ok)
	);

	assign in_part = (mem_req.addr >= PART_BASE) && (mem_req.addr <= PART_LIMIT);

	always_comb begin
		case (cpu_mode)
			MODE_SYS: mem_ok = !in_part;
			MODE_USR: mem_ok = !in_part && seg_ok && (boot_q == BOOT_RUN);
			MODE_CLS: mem_ok = in_part;
			default: mem_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			resp_q <= '0;
		end else if (ce) begin
			resp_q.done <= mem_req.valid;
			resp_q.grant <= mem_req.valid && mem_ok;
			resp_q.fault <= mem_req.valid && !mem_ok;
		end
	end

	assign mem_resp = resp_q;

	// ==========================================================
	// violation exception and interrupt
	logic [IRQ_W-1:0] evt;
	logic [IRQ_W-1:0] clr;

	assign evt[IRQ_MEM_BIT] = mem_req.valid && !mem_ok;
	assign evt[IRQ_REG_BIT] = access && den_q;
	assign clr = (wr_ok && paddr == OFF_IRQ_STAT) ? pwdata[IRQ_W-1:0] : IRQ_RST;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			exc_q <= 1'b0;
		end else if (ce) begin
			exc_q <= |evt;
		end
	end

	// set beats a same-cycle clear so no event is lost
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_q <= IRQ_RST;
		end else if (ce) begin
			irq_stat_q <= (irq_stat_q & ~clr) | evt;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_mask_q <= IRQ_RST;
		end else if (wr_ok && paddr == OFF_IRQ_MASK) begin
			irq_mask_q <= pwdata[IRQ_W-1:0];
		end
	end

	assign violation_exc = exc_q;
	assign irq = |(irq_stat_q & irq_mask_q);

	// ==========================================================
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_denied_setup;
		ce && setup && mapped && !allow;
	endsequence

	sequence s_access_edge;
		ce && access;
	endsequence

	a_part_read: assert property ((ce && setup && sys && !pwrite && paddr == OFF_PART) |=>
		(prdata == PART_CFG_VAL && !err_q))
		else $error("partition word not read back as fixed value");
	a_part_write: assert property ((ce && setup && pwrite && paddr == OFF_PART) |=> err_q)
		else $error("write to partition word not refused");
	a_seg_default: assert property ($rose(reset_n) |-> (seg_attr_q == SEG_ATTR_RST &&
		boot_q == BOOT_INIT))
		else $error("segments not closed after reset");
	a_boot_sticky: assert property ((boot_q == BOOT_RUN) |=> (boot_q == BOOT_RUN))
		else $error("boot stage left run state");
	a_ptr_guard: assert property ($changed(seg_ptr_q) |-> $past(wr_ok && paddr == OFF_PTR))
		else $error("segment pointer changed without accepted write");
	a_mmu_deny: assert property ((ce && setup && mapped && region == REGION_CTRL &&
		!sys) |=> (den_q && err_q))
		else $error("mmu register reachable outside privileged mode");
	a_per_sys: assert property ((ce && setup && sys && region == REGION_PER &&
		paddr[1:0] == WORD_ALIGN) |=> !err_q)
		else $error("privileged peripheral access refused");
	a_per_user: assert property ((ce && setup && cpu_mode == MODE_USR &&
		region == REGION_PER && !BASIC_MASK[per_idx] && !usr_grant_q[per_idx]) |=> err_q)
		else $error("ungranted peripheral register open to user mode");
	a_per_grant: assert property ((ce && setup && cpu_mode == MODE_CLS &&
		region == REGION_PER && paddr[1:0] == WORD_ALIGN && cls_grant_q[per_idx]) |=> !err_q)
		else $error("granted peripheral register refused");
	a_basic_hw: assert property ((ce && setup && region == REGION_PER &&
		paddr[1:0] == WORD_ALIGN && BASIC_MASK[per_idx]) |=> !err_q)
		else $error("basic register refused");
	a_reset_def: assert property ($rose(reset_n) |-> (per_q == '0 && usr_grant_q == GRANT_RST &&
		cls_grant_q == GRANT_RST))
		else $error("peripheral defaults not restored");
	a_deny_exc: assert property (s_denied_setup ##1 s_access_edge |=>
		(violation_exc && per_q == $past(per_q) && irq_stat_q[IRQ_REG_BIT]))
		else $error("denied register access not blocked or not reported");
	a_mem_fault: assert property ((ce && mem_req.valid && cpu_mode == MODE_USR && !seg_ok) |=>
		(mem_resp.fault && !mem_resp.grant && violation_exc))
		else $error("user access outside segments not faulted");

endmodule // mbac_top

`default_nettype wire

// file: tb/mbac_cpu_model.sv
// cpu core model: apb master for the register port and memory requester
// assumes the bench calls its tasks one at a time, from the clock domain
`timescale 1ns/1ps
`default_nettype none

module mbac_cpu_model (
	input wire logic clk,
	output var mbac_pkg::mbac_mode_t cpu_mode,
	output var mbac_pkg::mbac_mem_req_t mem_req,
	input wire mbac_pkg::mbac_mem_resp_t mem_resp,
	input wire logic violation_exc,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	import mbac_pkg::*;

	initial begin
		cpu_mode = MODE_SYS;
		mem_req = '0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// =============================================
	// apb transfer; exc is sampled one cycle after the access edge
	task automatic apb(input mbac_mode_t m, input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] rd, output logic err, output logic exc);
		@(posedge clk);
		cpu_mode <= m;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not keep the last value
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge clk);
		exc = violation_exc;
	endtask

	// =============================================
	// one memory request, answer one cycle after it is taken
	task automatic mem(input mbac_mode_t m, input logic w, input logic [31:0] a,
			output mbac_mem_resp_t r, output logic exc);
		@(posedge clk);
		cpu_mode <= m;
		mem_req <= '{1'b1, w, a};
		@(posedge clk);
		mem_req <= '{1'b0, ~w, ~a};
		@(posedge clk);
		r = mem_resp;
		exc = violation_exc;
	endtask
endmodule // mbac_cpu_model

`default_nettype wire

// file: tb/mode_based_access_control_bench.sv
// bench for the mode based access control block
// assumes the cpu model drives every cpu side input of the design
`timescale 1ns/1ps
`default_nettype none

module mode_based_access_control_bench;
	import mbac_pkg::*;

	typedef struct packed {
		mbac_mode_t m;
		logic w;
		logic [7:0] a;
		logic [31:0] d;
		logic e;
		logic x;
	} mbac_row_t;

	typedef struct packed {
		mbac_mode_t m;
		logic w;
		logic [31:0] a;
		logic g;
	} mbac_mrow_t;

	logic clk;
	logic reset_n;
	logic ce;
	logic psel, penable, pwrite, pready, pslverr, violation_exc, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, seg_table_ptr;
	logic [NPER-1:0][31:0] periph_ctrl;
	mbac_mode_t cpu_mode;
	mbac_mem_req_t mem_req;
	mbac_mem_resp_t mem_resp;
	int failures = 0;
	int compares = 0;

	mbac_top u_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_mode(cpu_mode), .mem_req(mem_req), .mem_resp(mem_resp),
		.periph_ctrl(periph_ctrl), .seg_table_ptr(seg_table_ptr),
		.violation_exc(violation_exc), .irq(irq));

	mbac_cpu_model u_cpu (.clk(clk), .cpu_mode(cpu_mode), .mem_req(mem_req),
		.mem_resp(mem_resp), .violation_exc(violation_exc), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// mode, write, addr, data, refused, exception
	mbac_row_t rows[] = '{
		'{MODE_SYS, 1'b0, 8'h00, PART_CFG_VAL, 1'b0, 1'b0},
		'{MODE_SYS, 1'b1, 8'h00, 32'hFFFFFFFF, 1'b1, 1'b0},
		'{MODE_SYS, 1'b0, 8'h00, PART_CFG_VAL, 1'b0, 1'b0},
		'{MODE_SYS, 1'b0, 8'h08, 32'h0, 1'b0, 1'b0},
		'{MODE_SYS, 1'b0, 8'h04, 32'h0, 1'b0, 1'b0},
		'{MODE_USR, 1'b1, 8'h04, 32'h1234, 1'b1, 1'b1},
		'{MODE_SYS, 1'b0, 8'h04, 32'h0, 1'b0, 1'b0},
		'{MODE_SYS, 1'b1, 8'h04, 32'h1234, 1'b0, 1'b0},
		'{MODE_SYS, 1'b0, 8'h04, 32'h1234, 1'b0, 1'b0},
		'{MODE_USR, 1'b0, 8'h08, 32'h0, 1'b1, 1'b1},
		'{MODE_CLS, 1'b1, 8'h08, 32'hFFF, 1'b1, 1'b1},
		'{MODE_USR, 1'b1, 8'h48, 32'h55, 1'b1, 1'b1},
		'{MODE_SYS, 1'b0, 8'h48, 32'h0, 1'b0, 1'b0},
		'{MODE_USR, 1'b1, 8'h40, 32'hA0, 1'b0, 1'b0},
		'{MODE_USR, 1'b0, 8'h40, 32'hA0, 1'b0, 1'b0},
		'{MODE_SYS, 1'b1, 8'h48, 32'hB2, 1'b0, 1'b0},
		'{MODE_SYS, 1'b0, 8'h48, 32'hB2, 1'b0, 1'b0},
		'{MODE_SYS, 1'b1, 8'h10, 32'h04, 1'b0, 1'b0},
		'{MODE_USR, 1'b0, 8'h48, 32'hB2, 1'b0, 1'b0},
		'{MODE_USR, 1'b1, 8'h4C, 32'h1, 1'b1, 1'b1},
		'{MODE_CLS, 1'b1, 8'h48, 32'h1, 1'b1, 1'b1},
		'{MODE_SYS, 1'b1, 8'h14, 32'h08, 1'b0, 1'b0},
		'{MODE_CLS, 1'b1, 8'h4C, 32'hC3, 1'b0, 1'b0},
		'{MODE_SYS, 1'b0, 8'h4C, 32'hC3, 1'b0, 1'b0},
		'{MODE_SYS, 1'b0, 8'h60, 32'h0, 1'b1, 1'b0},
		'{MODE_SYS, 1'b0, 8'h41, 32'h0, 1'b1, 1'b0},
		'{MODE_SYS, 1'b1, 8'h0C, 32'h1, 1'b0, 1'b0},
		'{MODE_SYS, 1'b0, 8'h0C, 32'h1, 1'b0, 1'b0},
		'{MODE_SYS, 1'b1, 8'h0C, 32'h0, 1'b1, 1'b0}
	};

	// segment 0 covers 0x1000-0x1FFF, read only
	mbac_mrow_t mrows[] = '{
		'{MODE_USR, 1'b0, 32'h1000, 1'b1},
		'{MODE_USR, 1'b0, 32'h1FFF, 1'b1},
		'{MODE_USR, 1'b0, 32'h2000, 1'b0},
		'{MODE_USR, 1'b1, 32'h1000, 1'b0},
		'{MODE_USR, 1'b0, 32'h8000, 1'b0},
		'{MODE_CLS, 1'b0, 32'h8000, 1'b1},
		'{MODE_CLS, 1'b1, 32'h8FFF, 1'b1},
		'{MODE_CLS, 1'b0, 32'h9000, 1'b0},
		'{MODE_SYS, 1'b0, 32'h8FFF, 1'b0},
		'{MODE_SYS, 1'b1, 32'h9000, 1'b1}
	};

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic acc(input mbac_row_t r);
		logic [31:0] rd;
		logic er, ex;
		u_cpu.apb(r.m, r.w, r.a, r.d, rd, er, ex);
		check(er, r.e);
		check(ex, r.x);
		if (!r.w)
			check(rd, r.d);
	endtask

	task automatic macc(input mbac_mrow_t r);
		mbac_mem_resp_t rs;
		logic ex;
		u_cpu.mem(r.m, r.w, r.a, rs, ex);
		check(rs.done, 1'b1);
		check(rs.grant, r.g);
		check(rs.fault, !r.g);
		check(ex, !r.g);
	endtask

	task automatic summarize();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		summarize();
	end

	// =============================================
	// main sequence
	initial begin
		reset_n = 1'b0;
		ce = 1'b1;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		foreach (rows[i])
			acc(rows[i]);
		$display("test register rows finished");
		acc('{MODE_SYS, 1'b1, 8'h20, 32'h1000, 1'b0, 1'b0});
		acc('{MODE_SYS, 1'b1, 8'h24, 32'h1FFF, 1'b0, 1'b0});
		// windows set but attributes still at their reset value
		macc('{MODE_USR, 1'b0, 32'h1000, 1'b0});
		acc('{MODE_SYS, 1'b1, 8'h08, 32'h011, 1'b0, 1'b0});
		acc('{MODE_SYS, 1'b0, 8'h08, 32'h011, 1'b0, 1'b0});
		foreach (mrows[i])
			macc(mrows[i]);
		$display("test memory rows finished");
		check(irq, 1'b0);
		acc('{MODE_SYS, 1'b1, 8'h1C, 32'h3, 1'b0, 1'b0});
		check(irq, 1'b1);
		acc('{MODE_SYS, 1'b0, 8'h18, 32'h3, 1'b0, 1'b0});
		acc('{MODE_SYS, 1'b1, 8'h18, 32'h3, 1'b0, 1'b0});
		check(irq, 1'b0);
		acc('{MODE_SYS, 1'b0, 8'h18, 32'h0, 1'b0, 1'b0});
		$display("test interrupt finished");
		@(posedge clk);
		ce <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		check(pready, 1'b0);
		ce <= 1'b1;
		$display("test clock enable finished");
		reset_n <= 1'b0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		check(periph_ctrl[2], 32'h0);
		check(seg_table_ptr, PTR_RST);
		check(irq, 1'b0);
		acc('{MODE_USR, 1'b0, 8'h48, 32'h0, 1'b1, 1'b1});
		acc('{MODE_SYS, 1'b0, 8'h08, 32'h0, 1'b0, 1'b0});
		acc('{MODE_SYS, 1'b0, 8'h00, PART_CFG_VAL, 1'b0, 1'b0});
		$display("test second reset finished");
		summarize();
	end
endmodule // mode_based_access_control_bench

`default_nettype wire
